// File: core/rtc_defs.svh
// register offsets, field positions and reset values of the counter block
// assumes byte addressing on a 32-bit apb bus, one word per register
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_IRQEN 8'h08
`define OFF_FLAGS 8'h0c
`define OFF_CALIB 8'h10
`define OFF_SRCSEL 8'h14
`define OFF_COUNT 8'h18
`define OFF_PERIOD 8'h1c
`define OFF_COMPARE 8'h20
`define OFF_PITCTRL 8'h24
`define OFF_PITSTATUS 8'h28
`define OFF_PITIRQEN 8'h2c
`define OFF_PITFLAGS 8'h30

`define CTRL_EN_BIT 0
`define CTRL_CORR_BIT 1
`define CTRL_PRESC_LSB 2
`define PIT_EN_BIT 0
`define PIT_IVAL_LSB 1
`define IEN_WRAP_BIT 0
`define IEN_MATCH_BIT 1
`define IEN_EWRAP_BIT 2
`define IEN_EMATCH_BIT 3
`define CALIB_SIGN_BIT 7

`define BUSY_CTRL 0
`define BUSY_CNT 1
`define BUSY_PER 2
`define BUSY_CMP 3
`define BUSY_PIT 4

`define PERIOD_RESET 16'hffff
`define PIT_IVAL_MIN 4'h1
`define PIT_IVAL_MAX 4'he
`define PIT_EVT_TOP 12
`define CORR_SLOT_BITS 13
`define LP_DIV_LAST 5'h1f

`endif

// File: core/rtc_pkg.sv
// types shared by the counter block and whoever connects it
// assumes an apb master on the same clock as the block
package rtc_pkg;

  typedef enum logic [1:0] {
    SRC_LP_OSC = 2'b00,
    SRC_LP_DIV32 = 2'b01,
    SRC_XTAL = 2'b10,
    SRC_EXT = 2'b11
  } ref_src_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

endpackage

// File: core/rtc_core.sv
// real-time counter and periodic tick timer on one shared prescaler
// assumes an apb master on clk_sys; oscillator pins are asynchronous
`timescale 1ns/100ps
`default_nettype none
`include "rtc_defs.svh"

module rtc_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire rtc_pkg::apb_req_t apb_req,
  output var rtc_pkg::apb_rsp_t apb_rsp,
  input wire logic xtal_in,
  input wire logic ext_clk_in,
  input wire logic lp_osc_in,
  output var logic irq_counter,
  output var logic irq_periodic,
  output var logic evt_wrap,
  output var logic evt_match,
  output var logic pit_wave,
  output var logic [7:0] pit_evt
);

  function automatic logic [14:0] low_mask(input logic [3:0] p);
    low_mask = 15'((16'h0001 << p) - 16'h0001);
  endfunction

  // pin synchronisers, third stage only for edge detection
  logic [2:0] pin_raw;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [4:0] div_q;
  assign pin_raw = {ext_clk_in, xtal_in, lp_osc_in};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else if (clk_en) begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  wire [2:0] pin_rise = s2_q & ~s3_q;
  wire div_rise = pin_rise[0] && (div_q == `LP_DIV_LAST);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div_q <= 5'h00;
    end else if (clk_en && pin_rise[0]) begin
      div_q <= div_q + 5'h01;
    end
  end

  // software-visible registers, plus internal prescaler, window and pit edge state
  rtc_pkg::ref_src_t src_q;
  logic [5:0] ctrl_q;
  logic [5:0] ctrl_p_q;
  logic [4:0] pit_q;
  logic [4:0] pit_p_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_p_q;
  logic [15:0] per_q;
  logic [15:0] per_p_q;
  logic [15:0] cmp_q;
  logic [15:0] cmp_p_q;
  logic [4:0] busy_q;
  logic [3:0] ien_q;
  logic pien_q;
  logic [1:0] flag_q;
  logic pflag_q;
  logic [7:0] calib_q;
  logic [14:0] presc_q;
  logic [19:0] win_q;
  logic pit_prev_q;

  wire ref_tick = (src_q == rtc_pkg::SRC_LP_OSC) ? pin_rise[0] :
                  (src_q == rtc_pkg::SRC_LP_DIV32) ? div_rise :
                  (src_q == rtc_pkg::SRC_XTAL) ? pin_rise[1] :
                  pin_rise[2];

  // apb decode
  wire [7:0] addr = apb_req.paddr;
  wire [31:0] wd = apb_req.pwdata;
  wire setup = apb_req.psel && !apb_req.penable;
  wire wr = apb_req.psel && apb_req.penable && apb_rsp.pready &&
            apb_req.pwrite;
  wire wr_ctrl = wr && (addr == `OFF_CTRL);
  wire wr_cnt = wr && (addr == `OFF_COUNT);
  wire wr_per = wr && (addr == `OFF_PERIOD);
  wire wr_cmp = wr && (addr == `OFF_COMPARE);
  wire wr_pit = wr && (addr == `OFF_PITCTRL);
  wire [4:0] wr_guard = {wr_pit, wr_cmp, wr_per, wr_cnt, wr_ctrl};
  wire [1:0] flag_clr = (wr && (addr == `OFF_FLAGS)) ? wd[1:0] : 2'h0;
  wire pflag_clr = wr && (addr == `OFF_PITFLAGS) && wd[0];

  // prescaler, correction and counter tick
  wire cnt_en = ctrl_q[`CTRL_EN_BIT];
  wire pit_en = pit_q[`PIT_EN_BIT];
  wire run_en = cnt_en || pit_en;
  wire [3:0] presc_sel = ctrl_q[`CTRL_PRESC_LSB +: 4];
  wire [3:0] ival = pit_q[`PIT_IVAL_LSB +: 4];
  wire [14:0] msk = low_mask(presc_sel);
  wire corr_on = ctrl_q[`CTRL_CORR_BIT] && (src_q == rtc_pkg::SRC_XTAL);
  wire corr_slot = (win_q[`CORR_SLOT_BITS-1:0] == 13'h0000) &&
                   (win_q[19:`CORR_SLOT_BITS] < calib_q[6:0]);
  wire skip = corr_on && corr_slot && calib_q[`CALIB_SIGN_BIT];
  wire insert = corr_on && corr_slot && !calib_q[`CALIB_SIGN_BIT];
  wire [1:0] step = skip ? 2'h2 : (insert ? 2'h0 : 2'h1);
  wire [15:0] low_sum = {1'b0, presc_q & msk} + {14'h0000, step};
  wire cnt_tick = ref_tick && cnt_en && (low_sum > {1'b0, msk});
  wire wrap_hit = cnt_tick && (cnt_q == per_q);
  wire match_hit = cnt_tick && (cnt_q == cmp_q);
  wire ival_ok = (ival >= `PIT_IVAL_MIN) && (ival <= `PIT_IVAL_MAX);
  wire pit_bit = pit_en && ival_ok && presc_q[ival];
  wire pit_hit = pit_bit && !pit_prev_q;
  wire [4:0] busy_d = (busy_q & ~{5{ref_tick}}) | wr_guard;
  wire [1:0] flag_d = (flag_q & ~flag_clr) | {match_hit, wrap_hit};
  wire pflag_d = (pflag_q && !pflag_clr) || pit_hit;

  wire [7:0] evt_taps;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_tap
      assign evt_taps[gi] = presc_q[`PIT_EVT_TOP - gi];
    end
  endgenerate

  // pending copies take software writes at once
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_p_q <= 6'h00;
      pit_p_q <= 5'h00;
      cnt_p_q <= 16'h0000;
      per_p_q <= `PERIOD_RESET;
      cmp_p_q <= 16'h0000;
      busy_q <= 5'h00;
    end else if (clk_en) begin
      if (wr_ctrl) ctrl_p_q <= wd[5:0];
      if (wr_pit) pit_p_q <= wd[4:0];
      if (wr_cnt) cnt_p_q <= wd[15:0];
      if (wr_per) per_p_q <= wd[15:0];
      if (wr_cmp) cmp_p_q <= wd[15:0];
      busy_q <= busy_d;
    end
  end

  // active copies move only on a reference edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q <= 6'h00;
      pit_q <= 5'h00;
      per_q <= `PERIOD_RESET;
      cmp_q <= 16'h0000;
    end else if (clk_en && ref_tick) begin
      if (busy_q[`BUSY_CTRL]) ctrl_q <= ctrl_p_q;
      if (busy_q[`BUSY_PIT]) pit_q <= pit_p_q;
      if (busy_q[`BUSY_PER]) per_q <= per_p_q;
      if (busy_q[`BUSY_CMP]) cmp_q <= cmp_p_q;
    end
  end

  // direct registers, no busy guard
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      src_q <= rtc_pkg::SRC_LP_OSC;
      ien_q <= 4'h0;
      pien_q <= 1'b0;
      calib_q <= 8'h00;
    end else if (clk_en && wr) begin
      if (addr == `OFF_SRCSEL) src_q <= rtc_pkg::ref_src_t'(wd[1:0]);
      if (addr == `OFF_IRQEN) ien_q <= wd[3:0];
      if (addr == `OFF_PITIRQEN) pien_q <= wd[0];
      if (addr == `OFF_CALIB) calib_q <= wd[7:0];
    end
  end

  // prescaler restarts from zero whenever both functions are off
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      presc_q <= 15'h0000;
      win_q <= 20'h00000;
    end else if (clk_en) begin
      if (!run_en) begin
        presc_q <= 15'h0000;
        win_q <= 20'h00000;
      end else if (ref_tick) begin
        presc_q <= presc_q + {13'h0000, step};
        win_q <= win_q + 20'h00001;
      end
    end
  end

  // a software count write overrides the running count
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
    end else if (clk_en) begin
      if (ref_tick && busy_q[`BUSY_CNT]) begin
        cnt_q <= cnt_p_q;
      end else if (wrap_hit) begin
        cnt_q <= 16'h0000;
      end else if (cnt_tick) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // flags: hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flag_q <= 2'h0;
      pflag_q <= 1'b0;
      pit_prev_q <= 1'b0;
    end else if (clk_en) begin
      flag_q <= flag_d;
      pflag_q <= pflag_d;
      pit_prev_q <= pit_bit;
    end
  end

  // outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_counter <= 1'b0;
      irq_periodic <= 1'b0;
      evt_wrap <= 1'b0;
      evt_match <= 1'b0;
      pit_wave <= 1'b0;
      pit_evt <= 8'h00;
    end else if (clk_en) begin
      irq_counter <= |(flag_q & ien_q[1:0]);
      irq_periodic <= pflag_q && pien_q;
      if (ref_tick) begin
        evt_wrap <= wrap_hit && ien_q[`IEN_EWRAP_BIT];
        evt_match <= match_hit && ien_q[`IEN_EMATCH_BIT];
      end
      pit_wave <= pit_bit;
      pit_evt <= pit_en ? evt_taps : 8'h00;
    end
  end

  // read mux, captured in the setup cycle
  wire hit = (addr <= `OFF_PITFLAGS) && (addr[1:0] == 2'b00);
  wire [31:0] rd_data =
    (addr == `OFF_CTRL) ? {26'h0, ctrl_q} :
    (addr == `OFF_STATUS) ? {28'h0, busy_q[3:0]} :
    (addr == `OFF_IRQEN) ? {28'h0, ien_q} :
    (addr == `OFF_FLAGS) ? {30'h0, flag_q} :
    (addr == `OFF_CALIB) ? {24'h0, calib_q} :
    (addr == `OFF_SRCSEL) ? {30'h0, src_q} :
    (addr == `OFF_COUNT) ? {16'h0, cnt_q} :
    (addr == `OFF_PERIOD) ? {16'h0, per_q} :
    (addr == `OFF_COMPARE) ? {16'h0, cmp_q} :
    (addr == `OFF_PITCTRL) ? {27'h0, pit_q} :
    (addr == `OFF_PITSTATUS) ? {31'h0, busy_q[`BUSY_PIT]} :
    (addr == `OFF_PITIRQEN) ? {31'h0, pien_q} :
    (addr == `OFF_PITFLAGS) ? {31'h0, pflag_q} : 32'h0;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      apb_rsp <= '0;
    end else if (clk_en) begin
      apb_rsp.pready <= setup;
      apb_rsp.pslverr <= setup && !hit;
      if (setup) apb_rsp.prdata <= rd_data;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  chk_wrap_reload: assert property (
    clk_en && wrap_hit && !busy_q[`BUSY_CNT] |=> cnt_q == 16'h0000)
    else $error("counter did not reload zero on wrap");

  chk_match_flag: assert property (
    clk_en && match_hit |=> flag_q[1])
    else $error("match flag not set after compare");

  chk_presc_stop: assert property (
    clk_en && !run_en |=> presc_q == 15'h0000)
    else $error("prescaler ran with both functions off");

  chk_busy_hold: assert property (
    clk_en && wr_ctrl && !ref_tick |=> busy_q[`BUSY_CTRL] &&
    ctrl_q == $past(ctrl_q))
    else $error("control write applied without reference edge");

  chk_irq_level: assert property (
    clk_en && flag_q[0] && ien_q[`IEN_WRAP_BIT] |=> irq_counter)
    else $error("counter irq low with flag and enable set");

  chk_evt_width: assert property (
    clk_en && evt_wrap && ref_tick && !wrap_hit |=> !evt_wrap)
    else $error("wrap event longer than one reference cycle");

  chk_pit_sixteen: assert property (
    clk_en && pit_en && ival == 4'h3 |=> pit_wave == $past(presc_q[3]))
    else $error("sixteen-cycle setting not following bit 3");

  chk_pit_start_zero: assert property (
    clk_en && $rose(pit_en) && !cnt_en |-> presc_q == 15'h0000)
    else $error("prescaler not at zero when periodic timer starts");

  chk_corr_skip: assert property (
    clk_en && run_en && ref_tick && skip |=>
    presc_q == $past(presc_q) + 15'h0002)
    else $error("prescaler did not jump two on a skip slot");

  chk_corr_insert: assert property (
    clk_en && run_en && ref_tick && insert |=> presc_q == $past(presc_q))
    else $error("prescaler moved on an insert slot");

endmodule
`default_nettype wire

// File: bench/tb.sv
// self-checking bench for rtc_core: apb master, oscillator pins, outputs
// assumes rtc_pkg and rtc_core compiled first, rtc_defs.svh on include path
`timescale 1ns/100ps
`default_nettype none
`include "rtc_defs.svh"
module tb;
  logic clk_sys = 0;
  logic rst_n = 0;
  logic clk_en = 1;
  logic xtal_in = 0;
  logic ext_clk_in = 0;
  logic lp_osc_in = 0;
  rtc_pkg::apb_req_t req = '0;
  rtc_pkg::apb_rsp_t rsp;
  logic irq_counter, irq_periodic, evt_wrap, evt_match, pit_wave;
  logic [7:0] pit_evt;
  logic [4:0] mon;
  logic [31:0] rd, c0;
  logic err;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int hi, lo, t0;

  always #50 clk_sys = ~clk_sys;
  // distinct pin rates so a wrong source select shows in the count
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    lp_osc_in <= cyc[2];
    xtal_in <= cyc[3];
    ext_clk_in <= cyc[4];
    if (cyc == 60000) begin
      n_errors++;
      print_verdict();
    end
  end
  assign mon = {pit_evt[7], pit_wave, evt_match, evt_wrap, irq_counter};

  rtc_core dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .apb_req(req), .apb_rsp(rsp), .xtal_in(xtal_in),
    .ext_clk_in(ext_clk_in), .lp_osc_in(lp_osc_in),
    .irq_counter(irq_counter), .irq_periodic(irq_periodic),
    .evt_wrap(evt_wrap), .evt_match(evt_match), .pit_wave(pit_wave),
    .pit_evt(pit_evt));

  task print_verdict;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input logic [31:0] got, input logic [31:0] l,
                        input logic [31:0] h);
    num_checks++;
    if ((got >= l && got <= h) !== 1'b1) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, l, h);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // polls both busy registers; guarded writes wait on this
  task automatic idle;
    int k;
    logic [31:0] b;
    k = 0;
    do begin
      apb(1'b0, `OFF_STATUS, 32'h0);
      b = rd;
      apb(1'b0, `OFF_PITSTATUS, 32'h0);
      k++;
    end while ((b | rd) !== 32'h0 && k < 500);
    chk(b | rd, 32'h0);
  endtask

  task automatic gw(input logic [7:0] a, input logic [31:0] d);
    idle();
    apb(1'b1, a, d);
  endtask

  task automatic pulse(input int i, output int h, output int l);
    int k;
    k = 0;
    while (mon[i] !== 1'b0 && k < 5000) begin
      @(posedge clk_sys);
      k++;
    end
    while (mon[i] !== 1'b1 && k < 5000) begin
      @(posedge clk_sys);
      k++;
    end
    h = 0;
    while (mon[i] === 1'b1 && h < 5000) begin
      @(posedge clk_sys);
      h++;
    end
    l = 0;
    while (mon[i] === 1'b0 && l < 5000) begin
      @(posedge clk_sys);
      l++;
    end
  endtask

  task automatic t_regs;
    apb(1'b0, `OFF_PERIOD, 32'h0);
    chk(rd, 32'h0000ffff);
    apb(1'b0, 8'h40, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, 8'h44, 32'h1);
    chk(err, 1'b1);
  endtask

  task automatic t_counter;
    apb(1'b1, `OFF_SRCSEL, 32'h0);
    gw(`OFF_PERIOD, 32'h3);
    gw(`OFF_COMPARE, 32'h1);
    apb(1'b1, `OFF_IRQEN, 32'hf);
    idle();
    @(posedge lp_osc_in);
    apb(1'b1, `OFF_CTRL, 32'h1);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(rd[`BUSY_CTRL], 1'b1);
    idle();
    apb(1'b0, `OFF_CTRL, 32'h0);
    chk(rd, 32'h1);
    pulse(1, hi, lo);
    chk(hi, 8);
    chk(lo, 24);
    pulse(2, hi, lo);
    chk(hi + lo, 32);
    apb(1'b0, `OFF_COUNT, 32'h0);
    chk_in(rd, 0, 3);
    gw(`OFF_CTRL, 32'h0);
    idle();
    apb(1'b0, `OFF_COUNT, 32'h0);
    c0 = rd;
    repeat (100) @(posedge clk_sys);
    apb(1'b0, `OFF_COUNT, 32'h0);
    chk(rd, c0);
    apb(1'b0, `OFF_FLAGS, 32'h0);
    chk(rd, 32'h3);
    chk(irq_counter, 1'b1);
    apb(1'b1, `OFF_IRQEN, 32'hc);
    repeat (3) @(posedge clk_sys);
    chk(irq_counter, 1'b0);
    apb(1'b1, `OFF_IRQEN, 32'h3);
    repeat (3) @(posedge clk_sys);
    chk(irq_counter, 1'b1);
    apb(1'b1, `OFF_FLAGS, 32'h3);
    repeat (3) @(posedge clk_sys);
    chk(irq_counter, 1'b0);
  endtask

  task automatic t_pit;
    apb(1'b1, `OFF_PITIRQEN, 32'h1);
    idle();
    t0 = cyc;
    apb(1'b1, `OFF_PITCTRL, 32'h7);
    while (pit_wave !== 1'b1 && cyc - t0 < 500) @(posedge clk_sys);
    chk_in(cyc - t0, 60, 96);
    pulse(3, hi, lo);
    chk({hi[15:0], lo[15:0]}, {16'd64, 16'd64});
    chk(irq_periodic, 1'b1);
    pulse(4, hi, lo);
    chk({hi[15:0], lo[15:0]}, {16'd256, 16'd256});
    gw(`OFF_PITCTRL, 32'h0);
    idle();
    repeat (3) @(posedge clk_sys);
    chk({pit_wave, pit_evt}, 9'h0);
    apb(1'b1, `OFF_PITFLAGS, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk(irq_periodic, 1'b0);
  endtask

  // source, prescale, expected counts in 1024 system cycles
  task automatic t_src;
    int tab [5][3] = '{'{0, 0, 128}, '{1, 0, 4}, '{2, 0, 64},
                       '{3, 0, 32}, '{0, 2, 32}};
    gw(`OFF_PERIOD, 32'hffff);
    for (int i = 0; i < 5; i++) begin
      gw(`OFF_CTRL, 32'h0);
      apb(1'b1, `OFF_SRCSEL, 32'(tab[i][0]));
      gw(`OFF_COUNT, 32'h0);
      gw(`OFF_CTRL, 32'(1 + 4 * tab[i][1]));
      idle();
      apb(1'b0, `OFF_COUNT, 32'h0);
      c0 = rd;
      repeat (1024) @(posedge clk_sys);
      apb(1'b0, `OFF_COUNT, 32'h0);
      chk_in(rd - c0, tab[i][2] - 1, tab[i][2] + 1);
    end
  endtask

  task automatic rise_wait(output int n);
    n = 0;
    while (pit_wave !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  // freeze, pit start on a running prescaler, then one skip and one insert
  task automatic t_corr;
    int n;
    apb(1'b0, `OFF_COUNT, 32'h0);
    c0 = rd;
    clk_en <= 1'b0;
    repeat (200) @(posedge clk_sys);
    clk_en <= 1'b1;
    apb(1'b0, `OFF_COUNT, 32'h0);
    chk_in(rd - c0, 0, 2);
    gw(`OFF_PITCTRL, 32'h7);
    rise_wait(n);
    chk_in(n, 0, 144);
    gw(`OFF_PITCTRL, 32'h0);
    gw(`OFF_CTRL, 32'h2);
    apb(1'b1, `OFF_SRCSEL, 32'h2);
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, `OFF_CALIB, s ? 32'h01 : 32'h81);
      idle();
      @(posedge xtal_in);
      apb(1'b1, `OFF_PITCTRL, 32'h7);
      rise_wait(n);
      chk_in(n, s ? 154 : 122, s ? 170 : 138);
      gw(`OFF_PITCTRL, 32'h0);
    end
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_counter();
    t_pit();
    t_src();
    t_corr();
    print_verdict();
  end
endmodule
`default_nettype wire
